// ---- rtl/char_display_instruction_decoder.sv ----
// Functional notes
// - clear fills every text memory location with blank code 20H
// - clear zeroes the pointer, selects text memory, sets increment mode
// - clear removes display shift; cursor goes to top-left character
// - display control stores display, cursor and blink bits; blink 1 Hz
// - shift moves the cursor by one, and with SC also the display, left or right, no memory access
// - two brightness bits set anode pulse width in four quarter steps
// - glyph address set selects glyph memory; pointer is 6 bits, wraps
// - text address set loads a 7-bit pointer and selects text memory
// - after a text address load, each access steps the pointer
// - valid text addresses are 00H-27H and 40H-67H, 40 per line
// - status read gives busy on bit 7 and the pointer below it
// - busy stays 1 while a command executes, 0 when ready
// - no new command is accepted while busy; host polls first
// - one pointer serves both memories, set by the last command
// - data read returns 8 bits from the memory last selected
// - a read without a prior address set returns invalid data first
// - a cursor shift prepares text reads like an address set
// - each data read taken while not busy steps the pointer by one per entry mode
// - each data write steps the pointer by one per entry mode
// - a read right after a write does not see the new pointer data
// - consecutive reads return successive addresses, each one stepping
`timescale 1ns/1ps
`default_nettype none
module char_display_instruction_decoder
  import disp_pkg::*;
#(
  parameter int unsigned BLINK_HALF_CYC = BLINK_HALF
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // refresh side
  input  wire logic [6:0]  scan_addr,
  output logic [7:0]       scan_data,
  output view_t            view
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one step of the shared pointer; text addresses hop between lines
  function automatic logic [6:0] step(input logic [6:0] p, input logic up,
                                      input logic cg);
    logic [5:0] g;
    g = up ? p[5:0] + 6'h01 : p[5:0] - 6'h01;
    if (cg) return {1'b0, g};
    if (up) return (p == L1_LAST) ? L2_FIRST : (p == L2_LAST) ? PTR_ZERO
                   : 7'(p + 7'h01);
    return (p == PTR_ZERO) ? L2_LAST : (p == L2_FIRST) ? L1_LAST
           : 7'(p - 7'h01);
  endfunction

  function automatic logic [5:0] shf(input logic [5:0] s, input logic right);
    if (right) return (s == SHIFT_LAST) ? 6'h00 : 6'(s + 6'h01);
    return (s == 6'h00) ? SHIFT_LAST : 6'(s - 6'h01);
  endfunction

  function automatic logic dd_ok(input logic [6:0] p);
    return (p <= L1_LAST) || (p >= L2_FIRST && p <= L2_LAST);
  endfunction

  function automatic reg_t dec(input logic [7:0] a);
    case (a)
      OFS_INSTR: return R_INS;
      OFS_DATA:  return R_DAT;
      OFS_VIEW:  return R_VIEW;
      default:   return R_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] text_mem  [0:127];
  logic [7:0] glyph_mem [0:63];
  state_t     s;
  state_t     n;
  logic       busy;
  logic       tw_en;
  logic       gw_en;
  logic [6:0] tw_addr;
  logic [7:0] w_data;
  logic [7:0] b;
  logic [7:0] rb;
  logic       done;
  logic       last;
  logic       ins_go;
  logic       dat_wr_go;
  logic       dat_rd_go;
  logic [7:0] mem_rd;

  assign busy   = (s.fsm != ST_IDLE);
  // one pointer addresses whichever memory was selected last
  assign mem_rd = s.cg ? glyph_mem[s.ptr[5:0]] : text_mem[s.ptr];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n         = s;
    tw_en     = 1'b0;
    gw_en     = 1'b0;
    tw_addr   = s.ptr;
    w_data    = BLANK_CODE;
    b         = 8'h00;
    rb        = 8'h00;
    done      = 1'b0;
    last      = 1'b0;
    ins_go    = 1'b0;
    dat_wr_go = 1'b0;
    dat_rd_go = 1'b0;
    n.scan    = text_mem[scan_addr];

    // blink phase: half period each way gives 50 percent duty
    if (s.bcnt == 27'(BLINK_HALF_CYC - 1)) begin
      n.bcnt       = 27'h000_0000;
      n.v.blink_ph = ~s.v.blink_ph;
    end else begin
      n.bcnt = 27'(s.bcnt + 27'h000_0001);
    end

    // brightness: anode on for 4, 3, 2 or 1 of every 4 steps
    if (s.pdiv == PWM_DIV) begin
      n.pdiv = 8'h00;
      n.pwm  = 2'(s.pwm + 2'h1);
    end else begin
      n.pdiv = 8'(s.pdiv + 8'h01);
    end
    n.v.anode = (s.pwm >= s.br);

    // read latch refills one cycle after the pointer settles
    if (s.fetch) begin
      n.latch = mem_rd;
      n.fetch = 1'b0;
    end

    // command execution
    case (s.fsm)
      ST_EXEC: begin
        if (s.cnt == 8'h00) n.fsm = ST_IDLE;
        else n.cnt = 8'(s.cnt - 8'h01);
      end
      ST_CLEAR: begin
        tw_en   = 1'b1;
        tw_addr = s.cnt[6:0];
        n.cnt   = 8'(s.cnt + 8'h01);
        if (s.cnt[6:0] == CLEAR_LAST) begin
          n.fsm   = ST_IDLE;
          n.fetch = 1'b1;
        end
      end
      default: ;
    endcase

    // bus: address phase, then one wait cycle in which the work is done
    if (hsel && htrans[1] && hready) begin
      n.dp     = 1'b1;
      n.dwr    = hwrite;
      n.dreg   = dec(haddr[7:0]);
      n.hready = 1'b0;
    end else if (s.dp) begin
      n.dp     = 1'b0;
      n.hready = 1'b1;
      n.hrdata = 32'h0000_0000;
      if (s.dwr) begin
        // a whole byte or a high nibble is refused while busy
        if ((s.dreg == R_INS || s.dreg == R_DAT) && !(busy && !s.half)) begin
          if (!s.v.bus8 && !s.half) begin
            n.half = 1'b1;
            n.nib  = hwdata[7:4];
          end else begin
            n.half = 1'b0;
            b      = s.v.bus8 ? hwdata[7:0] : {s.nib, hwdata[7:4]};
            done   = 1'b1;
          end
        end
      end else begin
        case (s.dreg)
          R_INS:   rb = {busy, s.ptr};
          R_DAT:   rb = s.latch;
          default: rb = 8'h00;
        endcase
        if ((s.dreg == R_INS || s.dreg == R_DAT) && !s.v.bus8) begin
          n.hrdata = {24'h00_0000, s.half ? rb[3:0] : rb[7:4], 4'h0};
          last     = s.half;
          n.half   = ~s.half;
        end else if (s.dreg == R_VIEW) begin
          n.hrdata = {18'h0_0000, s.v.shift, s.cg, s.inc, s.sh, s.v.disp,
                      s.v.cur, s.v.blk, s.v.two_line, s.v.bus8};
        end else begin
          n.hrdata = {24'h00_0000, rb};
          last     = 1'b1;
        end
        // a data read hands out the latch and moves on to the next cell
        if (s.dreg == R_DAT && last && !busy) begin
          dat_rd_go = 1'b1;
          n.ptr     = step(s.ptr, s.inc, s.cg);
          n.fetch   = 1'b1;
          n.fsm     = ST_EXEC;
          n.cnt     = EXEC_CYC;
        end
      end
    end

    // data write: no latch refill, so a following read sees stale data
    if (done && s.dreg == R_DAT) begin
      dat_wr_go = 1'b1;
      w_data    = b;
      tw_en     = !s.cg;
      gw_en     = s.cg;
      n.ptr     = step(s.ptr, s.inc, s.cg);
      if (s.sh && !s.cg) n.v.shift = shf(s.v.shift, !s.inc);
      n.fsm = ST_EXEC;
      n.cnt = EXEC_CYC;
    end

    // instruction decode
    if (done && s.dreg == R_INS) begin
      ins_go = 1'b1;
      n.fsm  = ST_EXEC;
      n.cnt  = EXEC_CYC;
      casez (b)
        8'b1???_????: begin
          n.ptr   = b[6:0];
          n.cg    = 1'b0;
          n.fetch = 1'b1;
        end
        8'b01??_????: begin
          n.ptr   = {1'b0, b[5:0]};
          n.cg    = 1'b1;
          n.fetch = 1'b1;
        end
        8'b001?_????: begin
          n.v.bus8     = b[B_IF];
          n.v.two_line = b[B_N];
          n.br         = b[1:0];
          n.half       = 1'b0;
        end
        8'b0001_????: begin
          n.ptr   = step(s.ptr, b[B_RL], s.cg);
          n.fetch = 1'b1;
          if (b[B_SC]) n.v.shift = shf(s.v.shift, b[B_RL]);
        end
        8'b0000_1???: begin
          n.v.disp = b[B_D];
          n.v.cur  = b[B_C];
          n.v.blk  = b[B_B];
        end
        8'b0000_01??: begin
          n.inc = b[B_ID];
          n.sh  = b[B_S];
        end
        8'b0000_001?: begin
          n.ptr     = PTR_ZERO;
          n.cg      = 1'b0;
          n.v.shift = 6'h00;
          n.fetch   = 1'b1;
        end
        8'b0000_0001: begin
          n.ptr     = PTR_ZERO;
          n.cg      = 1'b0;
          n.inc     = 1'b1;
          n.v.shift = 6'h00;
          n.fsm     = ST_CLEAR;
          n.cnt     = 8'h00;
        end
        default: ;
      endcase
    end

    // the cursor follows the pointer while text memory is selected
    if (!n.cg) n.v.cursor = n.ptr;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s            <= '0;
      s.fsm        <= ST_IDLE;
      s.dreg       <= R_NONE;
      s.inc        <= 1'b1;
      s.hready     <= 1'b1;
      s.v.bus8     <= 1'b1;
      s.v.two_line <= 1'b1;
      // full brightness is selected, so the anode is lit from the first cycle
      s.v.anode    <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // memories carry no reset; the clear command initialises text
  always_ff @(posedge hclk) begin
    if (tw_en) text_mem[tw_addr] <= w_data;
    if (gw_en) glyph_mem[s.ptr[5:0]] <= w_data;
  end

  assign hreadyout = s.hready;
  assign hrdata    = s.hrdata;
  assign hresp     = 1'b0;
  assign scan_data = s.scan;
  assign view      = s.v;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence clr_run;
    (s.fsm == ST_CLEAR && tw_en && w_data == BLANK_CODE) [*8];
  endsequence

  a_clear_fill: assert property (ins_go && b == CMD_CLEAR |=> clr_run)
    else $error("clear does not fill blanks");
  a_clear_ptr: assert property (ins_go && b == CMD_CLEAR |=>
      s.ptr == PTR_ZERO && !s.cg && s.inc && s.v.shift == 6'h00)
    else $error("clear leaves pointer or shift");
  a_home_keep: assert property (ins_go && b[7:1] == CMD_HOME7 |=>
      s.ptr == PTR_ZERO && !s.cg && s.v.shift == 6'h00 && !tw_en)
    else $error("home wrong");
  a_shift_nomem: assert property (ins_go && b[7:4] == CMD_SHIFT4 |->
      !tw_en && !gw_en)
    else $error("shift touched memory");
  a_glyph_wrap: assert property (s.cg |-> !s.ptr[6])
    else $error("glyph pointer above 6 bits");
  a_text_range: assert property (dat_wr_go && !s.cg && dd_ok(s.ptr) |=>
      dd_ok(s.ptr))
    else $error("text pointer left valid range");
  a_busy_set: assert property (ins_go |=> busy [*2])
    else $error("busy not held");
  // a low nibble completes a byte already taken, so it may land while busy
  a_busy_block: assert property (ins_go |-> !busy || s.half)
    else $error("command taken while busy");
  a_write_step: assert property (dat_wr_go |=>
      s.ptr == step($past(s.ptr), $past(s.inc), $past(s.cg)))
    else $error("write did not step");
  a_read_step: assert property (dat_rd_go |=> s.fetch &&
      s.ptr == step($past(s.ptr), $past(s.inc), $past(s.cg)) ##1
      s.latch == $past(mem_rd))
    else $error("read did not step and refill");
  a_status_read: assert property (s.dp && !s.dwr && s.dreg == R_INS &&
      s.v.bus8 |=> s.hrdata[7:0] == {$past(busy), $past(s.ptr)} && hreadyout)
    else $error("status word wrong");
  a_full_bright: assert property (s.br == BR_FULL |=> s.v.anode)
    else $error("anode off at full brightness");
  // the cursor only tracks text memory; glyph loads leave it parked
  a_cursor_track: assert property (!s.cg |-> s.v.cursor == s.ptr)
    else $error("cursor does not follow pointer");
  // every data phase costs one wait state, busy or not, so polls always end
  a_ready_wait: assert property (s.dp |-> !hreadyout ##1 hreadyout)
    else $error("data phase wait state wrong");
  // a data read while busy hands out the latch but must not move the pointer
  a_read_hold: assert property (s.dp && !s.dwr && s.dreg == R_DAT && busy |=>
      $stable(s.ptr))
    else $error("busy read moved pointer");

endmodule // char_display_instruction_decoder
`default_nettype wire

// ---- rtl/disp_pkg.sv ----
`default_nettype none
package disp_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_INSTR = 8'h00; // write instruction, read status
  localparam logic [7:0] OFS_DATA  = 8'h04; // write/read memory data
  localparam logic [7:0] OFS_VIEW  = 8'h08; // read-only block state

  // ----------------------------------------------------------------
  // codes, addresses and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] BLANK_CODE = 8'h20;
  localparam logic [7:0] CMD_CLEAR  = 8'h01;
  localparam logic [6:0] CMD_HOME7  = 7'h01;   // 02H..03H without bit 0
  localparam logic [3:0] CMD_SHIFT4 = 4'h1;    // 10H..1FH upper nibble
  localparam logic [6:0] PTR_ZERO   = 7'h00;
  localparam logic [6:0] L1_LAST    = 7'h27;
  localparam logic [6:0] L2_FIRST   = 7'h40;
  localparam logic [6:0] L2_LAST    = 7'h67;
  localparam logic [5:0] SHIFT_LAST = 6'h27;   // 40 columns
  localparam logic [6:0] CLEAR_LAST = 7'h7f;
  localparam logic [1:0] BR_FULL    = 2'h0;
  localparam int B_IF = 4;
  localparam int B_N  = 3;
  localparam int B_D  = 2;
  localparam int B_C  = 1;
  localparam int B_B  = 0;
  localparam int B_ID = 1;
  localparam int B_S  = 0;
  localparam int B_SC = 3;
  localparam int B_RL = 2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ    = 250;
  localparam int unsigned BLINK_MS   = 1000;    // 1.0 Hz period
  localparam int unsigned BLINK_HALF = BLINK_MS * CLK_MHZ * 1000 / 2;
  localparam logic [7:0]  EXEC_CYC   = 8'h02;   // busy time of a command
  localparam logic [7:0]  PWM_DIV    = 8'h3f;   // brightness step divider

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_CLEAR} fsm_t;
  typedef enum logic [1:0] {R_INS, R_DAT, R_VIEW, R_NONE} reg_t;

  typedef struct packed {
    logic       disp;
    logic       cur;
    logic       blk;
    logic       blink_ph;
    logic       anode;
    logic       two_line;
    logic       bus8;
    logic [5:0] shift;
    logic [6:0] cursor;
  } view_t;

  typedef struct packed {
    fsm_t        fsm;
    logic [7:0]  cnt;
    logic [6:0]  ptr;
    logic        cg;
    logic        inc;
    logic        sh;
    logic [1:0]  br;
    logic [7:0]  latch;
    logic        fetch;
    logic        half;
    logic [3:0]  nib;
    logic        dp;
    logic        dwr;
    reg_t        dreg;
    logic        hready;
    logic [31:0] hrdata;
    logic [1:0]  pwm;
    logic [7:0]  pdiv;
    logic [26:0] bcnt;
    logic [7:0]  scan;
    view_t       v;
  } state_t;

endpackage
`default_nettype wire

// ---- sim/host_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// host processor seen as an ahb-lite master, single word transfers
// ----------------------------------------------------------------
module host_bus_model (
  // clock
  input  wire logic        hclk,
  // master request
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  // slave answer
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  // idle bus until the first request
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
  end

  // address phase held until hready, then data phase held until hready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    // stale write data is inverted so nothing can lean on it
    hwdata <= ~wd;
  endtask
endmodule // host_bus_model
`default_nettype wire

// ---- sim/test_char_display_instruction_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_char_display_instruction_decoder
  import disp_pkg::*;
;
  // ----------------------------------------------------------------
  // signals and counters
  // ----------------------------------------------------------------
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic [6:0]  scan_addr;
  logic [7:0]  scan_data;
  view_t       view;
  int          failures;
  int          comparisons;

  // 250 MHz clock
  always #2 hclk = ~hclk;

  // short blink count keeps the run small
  char_display_instruction_decoder #(.BLINK_HALF_CYC(16)) i_char_display_instruction_decoder (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .scan_addr(scan_addr), .scan_data(scan_data), .view(view));

  host_bus_model i_host_bus_model (
    .hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r);
    i_host_bus_model.xfer(wr, a, {24'h00_0000, d}, r);
  endtask

  // poll status until ready; bounded so a stuck busy shows up
  task automatic idle();
    logic [31:0] r;
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      acc(1'b0, OFS_INSTR, 8'h00, r);
      // four-bit mode: fetch the low nibble too so the nibble phase stays paired
      if (view.bus8 === 1'b0) acc(1'b0, OFS_INSTR, 8'h00, q);
      n++;
    end while (r[7] !== 1'b0 && n < 300);
    chk(16'(r[7]), 16'h0000);
  endtask

  task automatic ins(input logic [7:0] d);
    logic [31:0] r;
    acc(1'b1, OFS_INSTR, d, r);
    idle();
  endtask

  task automatic dat(input logic [7:0] d);
    logic [31:0] r;
    acc(1'b1, OFS_DATA, d, r);
    idle();
  endtask

  task automatic rdd(input logic [7:0] exp);
    logic [31:0] r;
    acc(1'b0, OFS_DATA, 8'h00, r);
    chk(r[15:0], 16'(exp));
    idle();
  endtask

  task automatic ptr(input logic [6:0] exp);
    logic [31:0] r;
    acc(1'b0, OFS_INSTR, 8'h00, r);
    chk(r[15:0], 16'(exp));
  endtask

  task automatic mem(input logic [6:0] a, input logic [7:0] exp);
    scan_addr <= a;
    repeat (2) @(posedge hclk);
    chk(16'(scan_data), 16'(exp));
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(16'({hresp, view.bus8, view.two_line, view.disp, view.cur}), 16'h000c);
    ptr(7'h00);
    ins(8'h38);
  endtask

  task automatic t_clear();
    logic [31:0] r;
    acc(1'b1, OFS_INSTR, 8'h01, r);
    acc(1'b0, OFS_INSTR, 8'h00, r);
    chk(16'(r[7]), 16'h0001);
    acc(1'b1, OFS_INSTR, 8'h0f, r);
    idle();
    chk(16'(view.disp), 16'h0000);
    ptr(7'h00);
    chk(16'(view.shift), 16'h0000);
    mem(7'h00, 8'h20);
    mem(7'h27, 8'h20);
    mem(7'h67, 8'h20);
    mem(7'h7f, 8'h20);
  endtask

  task automatic t_write_read();
    ins(8'h85);
    dat(8'h41);
    dat(8'h42);
    ptr(7'h07);
    mem(7'h05, 8'h41);
    ins(8'h85);
    rdd(8'h41);
    rdd(8'h42);
    ptr(7'h07);
  endtask

  task automatic t_hops();
    ins(8'ha7);
    dat(8'h55);
    ptr(7'h40);
    ins(8'h04);
    ins(8'hc0);
    dat(8'h66);
    ptr(7'h27);
    ins(8'h06);
  endtask

  task automatic t_glyph();
    ins(8'h7f);
    dat(8'h1f);
    ptr(7'h00);
    ins(8'h7f);
    rdd(8'h1f);
  endtask

  task automatic t_shift();
    logic [6:0] c;
    ins(8'h85);
    c = view.cursor;
    ins(8'h14);
    chk(16'(view.cursor), 16'(c + 7'h01));
    ptr(7'h06);
    rdd(8'h42);
    ins(8'h1c);
    chk(16'(view.shift), 16'h0001);
    ins(8'h07);
    dat(8'h77);
    chk(16'(view.shift), 16'h0000);
    ins(8'h06);
    ins(8'h1c);
    ins(8'h02);
    chk(16'(view.shift), 16'h0000);
    ptr(7'h00);
    mem(7'h05, 8'h41);
  endtask

  task automatic t_control();
    logic p;
    ins(8'h0f);
    chk(16'({view.disp, view.cur, view.blk}), 16'h0007);
    p = view.blink_ph;
    repeat (16) @(posedge hclk);
    chk(16'(view.blink_ph ^ 1'b1), 16'(p));
    ins(8'h08);
    chk(16'({view.disp, view.cur, view.blk}), 16'h0000);
  endtask

  // anode high time over one full pwm cycle of 256 clocks
  task automatic t_function();
    int n;
    logic [31:0] r;
    for (int b = 0; b < 4; b++) begin
      ins(8'h38 | 8'(b));
      n = 0;
      repeat (256) begin
        @(posedge hclk);
        if (view.anode === 1'b1) n++;
      end
      chk(16'(n), 16'(256 - 64 * b));
    end
    ins(8'h30);
    chk(16'(view.two_line), 16'h0000);
    ins(8'h28);
    chk(16'(view.bus8), 16'h0000);
    // four-bit mode: the byte goes as two high nibbles
    acc(1'b1, OFS_INSTR, 8'h30, r);
    acc(1'b1, OFS_INSTR, 8'h80, r);
    repeat (8) @(posedge hclk);
    chk(16'({view.bus8, view.two_line}), 16'h0003);
    acc(1'b0, 8'h0c, 8'h00, r);
    chk(r[15:0], 16'h0000);
    // state word: no shift, text memory, increment, no shift-on-write, display, cursor and blink off, two lines, 8-bit bus
    acc(1'b0, OFS_VIEW, 8'h00, r);
    chk(r[15:0], 16'h0043);
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic end_of_test();
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    scan_addr = 7'h00;
    failures = 0;
    comparisons = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_clear();
    t_write_read();
    t_hops();
    t_glyph();
    t_shift();
    t_control();
    t_function();
    end_of_test();
  end

  // watchdog well beyond the few thousand cycles the tests need
  initial begin
    #100000;
    failures++;
    end_of_test();
  end
endmodule // test_char_display_instruction_decoder
`default_nettype wire
